// ===== core/shadow_bank.sv
// Purpose: configuration bank with shadowed setup and feature bytes
// Assumes: serial front end delivers whole bytes with their address
// Notes:   staged values reach the converter only after a transfer
//
// Notes on behaviour
// [R1] host writes zeros into unused bits of partly used locations
// [R2] host never writes a location whose bits are all unused
// [R3] every reset loads each configuration register with its default
// [R4] locations 0x08 to 0x20, 0x3C, 0x3E write only a staging copy
// [R5] writing 0x01 to 0xFF sets the transfer bit, the commit command
// [R6] commit copies every staged byte to the active copy at once
// [R7] transfer bit clears itself after the update, no host action
// [R8] access is a 16-bit instruction then 8-bit data words
// [R9] writes to unsupported addresses or bits change nothing
`timescale 1ns/1ps
module shadow_bank (
  // clock and reset
  input  wire  logic                                     sys_clk,
  input  wire  logic                                     srst,
  // byte write port from the serial front end
  input  wire  logic                                     wr_strobe,
  input  wire  logic [shadow_pkg::ADDR_W-1:0]            wr_addr,
  input  wire  logic [shadow_pkg::DATA_W-1:0]            wr_data,
  // byte read port to the serial front end
  input  wire  logic [shadow_pkg::ADDR_W-1:0]            rd_addr,
  output logic       [shadow_pkg::DATA_W-1:0]            rd_data,
  // operating configuration
  output logic       [shadow_pkg::NUM_SLOTS*8-1:0]       active_cfg,
  output logic                                           lsb_first,
  output logic                                           commit_pulse
);
  import shadow_pkg::*;

  // ==========================================================
  // address decode shared by the write and read paths
  function automatic logic is_shadowed(input logic [7:0] a);
    is_shadowed = ((a >= SHADOW_LO) && (a <= SHADOW_HI)) ||
                  (a == ADDR_FEAT_A) || (a == ADDR_FEAT_B);
  endfunction

  function automatic logic [4:0] slot_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - SHADOW_LO;
    if (a == ADDR_FEAT_A) begin
      slot_of = SLOT_FEAT_A;
    end else if (a == ADDR_FEAT_B) begin
      slot_of = SLOT_FEAT_B;
    end else begin
      slot_of = off[4:0];
    end
  endfunction

  // port configuration byte as the host reads it back; both nibbles mirror
  // the bit order and soft reset flags so either shift order decodes them
  function automatic logic [7:0] cfg_byte(input logic lsb, input logic rst);
    cfg_byte = CFG_FIXED |
               (8'(lsb) << CFG_LSB_HI) |
               (8'(lsb) << CFG_LSB_LO) |
               (8'(rst) << CFG_SRST_HI) |
               (8'(rst) << CFG_SRST_LO);
  endfunction

  // ==========================================================
  // internal state
  logic       xfer_q;
  logic       soft_rst_q;
  logic       lsb_first_q;
  logic [7:0] rd_data_q;
  logic       wr_shadow;
  logic [4:0] wr_slot;
  logic [7:0] wr_mask;
  logic       wr_xfer;
  logic       wr_cfg;
  logic       wr_soft_rst;
  logic [7:0] rd_stage [NUM_SLOTS];
  // next values of the flag and read registers
  logic       xfer_d;
  logic       lsb_first_d;
  logic [7:0] rd_data_d;

  // ==========================================================
  // write decode
  // [R8] one byte per data word
  assign wr_shadow   = wr_strobe && is_shadowed(wr_addr);
  assign wr_slot     = slot_of(wr_addr);
  assign wr_mask     = slot_mask(wr_slot);
  assign wr_xfer     = wr_strobe && (wr_addr == ADDR_XFER);
  assign wr_cfg      = wr_strobe && (wr_addr == ADDR_CFG);
  // either mirrored copy of the soft reset bit triggers it
  assign wr_soft_rst = wr_cfg && (wr_data[CFG_SRST_HI] || wr_data[CFG_SRST_LO]);

  // ==========================================================
  // shadowed slots, one staging and one active byte each
  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      slot_if sif ();

      // [R3] defaults on any reset
      assign sif.load_default = soft_rst_q;
      // [R9] open locations and open bits never stored
      assign sif.stage_we     = wr_shadow && (wr_slot == 5'(g)) &&
                                (wr_mask != MASK_OPEN);
      // [R1] unused bits kept at zero
      assign sif.stage_data   = wr_data & wr_mask;
      // [R6] one shared commit strobe
      assign sif.commit       = xfer_q;

      assign rd_stage[g]              = sif.stage_q;
      assign active_cfg[g*8 +: 8]     = sif.active_q;

      shadow_slot #(
        .RESET_VAL (slot_default(5'(g)))
      ) u_slot (
        .sys_clk (sys_clk),
        .srst    (srst),
        .sif     (sif.slot)
      );
    end
  endgenerate

  // ==========================================================
  // transfer bit next value: set by the host, cleared by the update itself
  // a new transfer write in the clearing cycle wins, so it is not lost
  // [R5] transfer write commits
  always_comb begin
    xfer_d = 1'b0;
    if (wr_xfer && wr_data[XFER_BIT]) begin
      xfer_d = 1'b1;
    end
  end

  // ==========================================================
  // transfer bit register; it stands one cycle, then clears by itself
  // a soft reset in flight drops a pending commit, defaults win over it
  // [R7] self-clearing after update
  always_ff @(posedge sys_clk) begin
    if (srst || soft_rst_q) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= xfer_d;
    end
  end

  assign commit_pulse = xfer_q;

  // ==========================================================
  // soft reset: self-clearing one-cycle pulse
  // reload lands one edge after the write, so that byte's bit order is overridden
  // [R3] soft reset reloads defaults
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_soft_rst;
    end
  end

  // ==========================================================
  // port configuration: bit order choice, not shadowed
  // takes effect at once so the front end can switch mid-session
  // either mirrored copy of the bit order flag selects LSB first
  always_comb begin
    lsb_first_d = lsb_first_q;
    if (wr_cfg) begin
      lsb_first_d = wr_data[CFG_LSB_HI] || wr_data[CFG_LSB_LO];
    end
  end

  // bit order register, back to MSB first on either reset
  always_ff @(posedge sys_clk) begin
    if (srst || soft_rst_q) begin
      lsb_first_q <= CFG_RESET[CFG_LSB_HI];
    end else begin
      lsb_first_q <= lsb_first_d;
    end
  end

  assign lsb_first = lsb_first_q;

  // ==========================================================
  // readback value: shadowed locations show the staged byte
  // open addresses read as zero, so a host probing the map sees no junk
  always_comb begin
    rd_data_d = READ_ZERO;
    if (is_shadowed(rd_addr)) begin
      rd_data_d = rd_stage[slot_of(rd_addr)];
    end else begin
      case (rd_addr)
        ADDR_CFG: begin
          rd_data_d = cfg_byte(lsb_first_q, soft_rst_q);
        end
        ADDR_ID: begin
          rd_data_d = CHIP_ID_VAL;
        end
        ADDR_GRADE: begin
          rd_data_d = GRADE_VAL;
        end
        ADDR_XFER: begin
          rd_data_d = 8'(xfer_q) << XFER_BIT;
        end
        default: begin
          rd_data_d = READ_ZERO;
        end
      endcase
    end
  end

  // ==========================================================
  // read data register; one cycle of latency keeps the decode off the pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_data_q <= READ_ZERO;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;

endmodule

// ===== core/shadow_pkg.sv
// Purpose: constants shared by the shadowed configuration bank
// Assumes: one byte-wide register per address, 8-bit address space
// Notes:   per-location reset values and used-bit masks are functions
package shadow_pkg;

  // ==========================================================
  // widths and address map
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned NUM_SLOTS   = 27;
  localparam int unsigned SLOT_W      = 5;
  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_ID     = 8'h01;
  localparam logic [7:0]  ADDR_GRADE  = 8'h02;
  localparam logic [7:0]  ADDR_XFER   = 8'hff;
  localparam logic [7:0]  SHADOW_LO   = 8'h08;
  localparam logic [7:0]  SHADOW_HI   = 8'h20;
  localparam logic [7:0]  ADDR_FEAT_A = 8'h3c;
  localparam logic [7:0]  ADDR_FEAT_B = 8'h3e;
  localparam logic [4:0]  SLOT_FEAT_A = 5'h19;
  localparam logic [4:0]  SLOT_FEAT_B = 5'h1a;

  // ==========================================================
  // port configuration register fields
  localparam logic [7:0]  CFG_RESET   = 8'h18;
  localparam logic [7:0]  CFG_FIXED   = 8'h18;
  localparam int unsigned CFG_LSB_HI  = 6;
  localparam int unsigned CFG_LSB_LO  = 1;
  localparam int unsigned CFG_SRST_HI = 5;
  localparam int unsigned CFG_SRST_LO = 2;

  // ==========================================================
  // transfer register and read-only values
  localparam int unsigned XFER_BIT    = 0;
  localparam logic [7:0]  XFER_CMD    = 8'h01;
  localparam logic [7:0]  CHIP_ID_VAL = 8'h5a; // arbitrary value
  localparam logic [7:0]  GRADE_VAL   = 8'h00; // arbitrary value
  localparam logic [7:0]  READ_ZERO   = 8'h00;

  // ==========================================================
  // per-slot reset value; slot 12 is the output mode location
  localparam logic [4:0]  SLOT_OUTMODE  = 5'h0c;
  localparam logic [7:0]  OUTMODE_RESET = 8'h01;
  localparam logic [7:0]  SLOT_RESET    = 8'h00;
  // slot 11 is a wholly open location, all others fully used
  localparam logic [4:0]  SLOT_OPEN     = 5'h0b;
  localparam logic [7:0]  MASK_OPEN     = 8'h00;
  localparam logic [7:0]  MASK_FULL     = 8'hff;

  function automatic logic [7:0] slot_default(input logic [4:0] idx);
    slot_default = (idx == SLOT_OUTMODE) ? OUTMODE_RESET : SLOT_RESET;
  endfunction

  function automatic logic [7:0] slot_mask(input logic [4:0] idx);
    slot_mask = (idx == SLOT_OPEN) ? MASK_OPEN : MASK_FULL;
  endfunction

endpackage

// ===== core/shadow_slot.sv
// Purpose: one shadowed configuration byte, staging plus active copy
// Assumes: commands from the bank arrive as one-cycle pulses
// Notes:   reset value is fixed per instance
`timescale 1ns/1ps
module shadow_slot #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // bank side
  slot_if.slot      sif
);
  import shadow_pkg::*;

  logic [7:0] stage_q;
  logic [7:0] active_q;

  // ==========================================================
  // staging copy
  // [R4] writes held in staging
  always_ff @(posedge sys_clk) begin
    if (srst || sif.load_default) begin
      stage_q <= RESET_VAL;
    end else if (sif.stage_we) begin
      stage_q <= sif.stage_data;
    end
  end

  // ==========================================================
  // active copy; only a commit moves staging across
  // [R6] simultaneous copy on commit
  always_ff @(posedge sys_clk) begin
    if (srst || sif.load_default) begin
      active_q <= RESET_VAL;
    end else if (sif.commit) begin
      active_q <= stage_q;
    end
  end

  assign sif.stage_q  = stage_q;
  assign sif.active_q = active_q;

endmodule

// ===== core/slot_if.sv
// Purpose: carrier between the bank decoder and one shadowed byte
// Assumes: single clock domain
// Notes:   bank drives commands, slot returns both copies
`timescale 1ns/1ps
interface slot_if;
  logic       load_default;
  logic       stage_we;
  logic [7:0] stage_data;
  logic       commit;
  logic [7:0] stage_q;
  logic [7:0] active_q;

  modport bank (output load_default, output stage_we, output stage_data,
                output commit, input stage_q, input active_q);
  modport slot (input load_default, input stage_we, input stage_data,
                input commit, output stage_q, output active_q);
endinterface

// ===== test/cfg_host.sv
// Purpose: serial host model feeding whole bytes to the bank
// Assumes: caller is aligned to a falling edge
// Notes:   each task returns on the next falling edge
`timescale 1ns/1ps
module cfg_host (
  // clock
  input wire logic  sys_clk,
  // bank ports
  output logic       wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  initial begin
    wr_strobe = 1'b0;
    wr_addr   = 8'h00;
    wr_data   = 8'h00;
    rd_addr   = 8'h00;
  end
  // no unused bits, open 0x13 never strobed
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_strobe = (a != 8'h13);
    wr_addr   = a;
    wr_data   = d;
    @(negedge sys_clk);
  endtask
  // released lines show the inverse of the last byte, not a stale copy
  task automatic idle();
    wr_strobe = 1'b0;
    wr_addr   = ~wr_addr;
    wr_data   = ~wr_data;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    wr_strobe = 1'b0;
    rd_addr   = a;
    @(negedge sys_clk);
    d = rd_data;
  endtask
endmodule

// ===== test/shadow_bank_properties.sv
// Purpose: port-level checks of the shadowed configuration bank
// Assumes: one clock, srst synchronous active high
// Notes:   staging is visible only through rd_data
`timescale 1ns/1ps
module shadow_bank_properties (
  // clock and reset
  input wire logic         sys_clk,
  input wire logic         srst,
  // observed ports
  input wire logic         wr_strobe,
  input wire logic [7:0]   wr_addr,
  input wire logic [7:0]   wr_data,
  input wire logic [7:0]   rd_addr,
  input wire logic [7:0]   rd_data,
  input wire logic [215:0] active_cfg,
  input wire logic         lsb_first,
  input wire logic         commit_pulse
);
  import shadow_pkg::*;
  // ==========================================================
  // write decodes
  logic xfer_w;
  logic soft_w;
  assign xfer_w = wr_strobe && wr_addr == ADDR_XFER && wr_data[XFER_BIT];
  assign soft_w = wr_strobe && wr_addr == ADDR_CFG && (wr_data[5] || wr_data[2]);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_commit_after_xfer: assert property (xfer_w |=> commit_pulse)
    else $error("no commit pulse after transfer write");
  a_commit_self_clear: assert property (!xfer_w |=> !commit_pulse)
    else $error("commit pulse without a fresh transfer write");
  // soft reset reload is excluded for three cycles, the write and the two after, its exact edge is internal
  a_active_only_commit: assert property (!commit_pulse && !soft_w && !$past(soft_w)
    && !$past(soft_w, 2) |=> $stable(active_cfg))
    else $error("active copy moved without commit");
  a_reset_defaults: assert property (disable iff (1'b0) srst |=>
    active_cfg == (216'h1 << 96) && !commit_pulse && !lsb_first && rd_data == 8'h00)
    else $error("reset did not load defaults");
  a_open_reads_zero: assert property (rd_addr == 8'h13 |=> rd_data == 8'h00)
    else $error("open location reads nonzero");
  a_unmapped_zero: assert property (rd_addr inside {[8'h21:8'h3b]} |=> rd_data == 8'h00)
    else $error("unmapped location reads nonzero");
  a_chip_id_fixed: assert property (rd_addr == ADDR_ID |=> rd_data == CHIP_ID_VAL)
    else $error("read-only identity changed");
  a_bit_order_set: assert property (wr_strobe && wr_addr == ADDR_CFG && !soft_w
    && wr_data[6] == wr_data[1] |=> lsb_first == $past(wr_data[6]))
    else $error("bit order flag not updated");
endmodule
bind shadow_bank shadow_bank_properties u_props (.sys_clk(sys_clk), .srst(srst),
  .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
  .rd_data(rd_data), .active_cfg(active_cfg), .lsb_first(lsb_first),
  .commit_pulse(commit_pulse));

// ===== test/shadow_bank_tb.sv
// Purpose: directed checks of staging, commit and defaults
// Assumes: inputs change on the falling edge
// Notes:   expectations mix package constants and literal values
`timescale 1ns/1ps
module shadow_bank_tb;
  import shadow_pkg::*;
  logic         sys_clk, srst, wr_strobe, lsb_first, commit_pulse;
  logic [7:0]   wr_addr, wr_data, rd_addr, rd_data;
  logic [215:0] active_cfg, exp_cfg, def_cfg;
  int           miscompares = 0, cmp_count = 0, cycles = 0, k;
  shadow_bank DUT (.sys_clk(sys_clk), .srst(srst), .wr_strobe(wr_strobe),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .active_cfg(active_cfg), .lsb_first(lsb_first), .commit_pulse(commit_pulse));
  cfg_host host (.sys_clk(sys_clk), .wr_strobe(wr_strobe), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic check(input logic [215:0] seen, input logic [215:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    check(v, exp);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  function automatic logic [7:0] slot_addr(input int i);
    return (i < 25) ? 8'h08 + i[7:0] : ((i == 25) ? ADDR_FEAT_A : ADDR_FEAT_B);
  endfunction
  // hang guard, the run needs about sixty cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 2000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    srst = 1'b1;
    def_cfg = 216'h1 << 96;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check(active_cfg, def_cfg);
    rchk(8'h14, OUTMODE_RESET);
    rchk(ADDR_CFG, CFG_RESET);
    // stage every shadowed byte back to back, open slot skipped
    exp_cfg = def_cfg;
    for (k = 0; k < 27; k++) begin
      if (k != 11) begin
        host.wr(slot_addr(k), slot_addr(k) ^ 8'h5a);
        exp_cfg[8*k +: 8] = slot_addr(k) ^ 8'h5a;
      end
    end
    host.idle();
    check(active_cfg, def_cfg);
    rchk(8'h20, 8'h7a);
    rchk(ADDR_FEAT_B, 8'h64);
    host.wr(ADDR_XFER, 8'h00);
    check(commit_pulse, 1'b0);
    host.wr(ADDR_XFER, XFER_CMD);
    check(commit_pulse, 1'b1);
    check(active_cfg, def_cfg);
    host.idle();
    check(active_cfg, exp_cfg);
    check(commit_pulse, 1'b0);
    rchk(ADDR_XFER, 8'h00);
    // unsupported and read-only places
    host.wr(8'h30, 8'hff);
    host.wr(ADDR_ID, 8'h00);
    rchk(8'h30, 8'h00);
    rchk(8'h13, 8'h00);
    rchk(ADDR_ID, CHIP_ID_VAL);
    check(active_cfg, exp_cfg);
    host.wr(ADDR_CFG, 8'h5a);
    host.idle();
    check(lsb_first, 1'b1);
    rchk(ADDR_CFG, 8'h5a);
    host.wr(ADDR_CFG, CFG_RESET);
    host.idle();
    check(lsb_first, 1'b0);
    // soft reset through the port configuration byte
    host.wr(ADDR_CFG, 8'h3c);
    repeat (3) host.idle();
    check(active_cfg, def_cfg);
    rchk(8'h20, 8'h00);
    // second hard reset in mid-run
    host.wr(8'h08, 8'h77);
    host.wr(ADDR_XFER, XFER_CMD);
    host.idle();
    check(active_cfg[7:0], 8'h77);
    srst = 1'b1;
    repeat (2) host.idle();
    srst = 1'b0;
    check(active_cfg, def_cfg);
    rchk(8'h08, 8'h00);
    print_verdict();
  end
endmodule
